/* design/clock_network_control.sv */
// device end: per-network source select, gating and external pin output
//
// Overview of operation
// - first variant: 24 regional, eight global networks
// - second variant: 20 regional, four global networks
// - only counters zero to three reach global inputs two, three
// - center references direct, corner references 4:1 muxed
// - each network has its own control instance
// - two-bit select picks one of four inputs
// - inputs zero, one take any same-side pin
// - input two from counter zero or two
// - input three from counter one or three
// - left side: counters four/six, and five
// - regional source fixed by configuration only
// - static selects ignore changes in user mode
// - powered-down network delivers no clock
// - unused networks held down from user start
// - per-network enable applied synchronously to clock
// - gating works with or without a pll
// - external output pin has its own enable
// - pin mux picks internal signal or clock
// - dynamic sources should share one side
// - switch between plls, or pins and plls
// - enable sampled on falling gated-clock edge
// - bypassable sync register on enable path
// - gating never touches pll feedback counters
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module clock_network_control
    import clock_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [PIN_COUNT-1:0] clock_pin,
    input wire logic [PLL_CNT-1:0] pll_a_counter,
    input wire logic [PLL_CNT-1:0] pll_b_counter,
    input wire logic [GLB_NETS-1:0][GCFG_W-1:0] cfg_global,
    input wire logic [RGN_NETS-1:0][RCFG_W-1:0] cfg_regional,
    input wire logic [ECFG_W-1:0] cfg_ext,
    clock_ctrl_if.device core_if,
    output logic pll_external_output_pin,
    output logic [PIN_COUNT-1:0] center_pll_reference,
    output logic corner_pll_reference
);
    localparam int GLB_LIMIT = VARIANT_TWO ? GLB_NETS_V2 : GLB_NETS;
    localparam int RGN_LIMIT = VARIANT_TWO ? RGN_NETS_V2 : RGN_NETS;

    logic [SRC_W-1:0] sync1_r;
    logic [SRC_W-1:0] sync2_r;
    logic [SRC_W-1:0] sync3_r;
    logic [SRC_W-1:0] level_r;
    cfg_phase_t phase_r;
    logic [GLB_NETS-1:0][GCFG_W-1:0] gcfg_r;
    logic [RGN_NETS-1:0][RCFG_W-1:0] rcfg_r;
    logic [ECFG_W-1:0] ecfg_r;
    logic [GLB_NETS-1:0][1:0] sel_r;
    logic ext_gated;
    logic ext_pin_r;
    logic [PIN_COUNT-1:0] center_ref_r;
    logic corner_ref_r;
    wire logic [SRC_W-1:0] raw_src;
    wire logic [SRC_W-1:0] agree;
    wire logic [PIN_COUNT-1:0] pins;
    wire logic [PLL_CNT-1:0] pll_a;
    wire logic [PLL_CNT-1:0] pll_b;

    // every source arrives from outside this clock: three-stage sampling
    assign raw_src = {pll_b_counter, pll_a_counter, clock_pin};
    assign agree = ~(sync2_r ^ sync3_r);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            level_r <= '0;
        end else begin
            sync1_r <= raw_src;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= (agree & sync3_r) | (~agree & level_r);
        end
    end

    assign pins = level_r[PIN_COUNT-1:0];
    assign pll_a = level_r[SRC_PLL_A +: PLL_CNT];
    assign pll_b = level_r[SRC_PLL_B +: PLL_CNT];

    // configuration bits caught once after reset, then frozen
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= CFG_LOAD;
            gcfg_r <= '0;
            rcfg_r <= '0;
            ecfg_r <= '0;
        end else begin
            case (phase_r)
                CFG_LOAD: begin
                    gcfg_r <= cfg_global;
                    rcfg_r <= cfg_regional;
                    ecfg_r <= cfg_ext;
                    phase_r <= CFG_USER;
                end
                CFG_USER: begin
                    phase_r <= CFG_USER;
                end
                default: begin
                    phase_r <= CFG_LOAD;
                end
            endcase
        end
    end

    // dynamic select from core, registered once; same clock, no sync
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_r <= '0;
        end else begin
            sel_r <= core_if.source_select;
        end
    end

    // one control instance per global network
    genvar g;
    generate
        for (g = 0; g < GLB_NETS; g++) begin : glb
            localparam bit PERMIT = (g < GLB_LIMIT);
            wire logic left;
            wire logic [1:0] pin0_idx;
            wire logic [1:0] pin1_idx;
            wire logic [PLL_CNT-1:0] pll2;
            wire logic [PLL_CNT-1:0] pll3;
            wire logic [3:0] cand;
            wire logic src;
            // left side of first variant exists only there
            assign left = gcfg_r[g][GCFG_LEFT] & ~VARIANT_TWO;
            assign pin0_idx = gcfg_r[g][GCFG_PIN0 +: 2];
            assign pin1_idx = gcfg_r[g][GCFG_PIN1 +: 2];
            assign pll2 = gcfg_r[g][GCFG_IN2_PLL] ? pll_b : pll_a;
            assign pll3 = gcfg_r[g][GCFG_IN3_PLL] ? pll_b : pll_a;
            // inputs zero and one: same-side pins, or left-side counters
            assign cand[SEL_PIN_A] = left ?
                (gcfg_r[g][GCFG_LEFT_C6] ? pll_a[CNT_SIX] : pll_a[CNT_FOUR])
                : pins[pin0_idx];
            assign cand[SEL_PIN_B] = left ? pll_a[CNT_FIVE]
                : pins[pin1_idx];
            // inputs two and three: counters zero to three only
            assign cand[SEL_PLL_EVEN] = gcfg_r[g][GCFG_IN2_CNT] ?
                pll2[CNT_TWO] : pll2[CNT_ZERO];
            assign cand[SEL_PLL_ODD] = gcfg_r[g][GCFG_IN3_CNT] ?
                pll3[CNT_THREE] : pll3[CNT_ONE];
            assign src = cand[sel_r[g]];
            net_gate u_gate (
                .clk(clk),
                .nrst(nrst),
                .src(src),
                .enable(core_if.glb_enable[g]),
                .bypass(gcfg_r[g][GCFG_BYPASS]),
                .used(gcfg_r[g][GCFG_USED] & PERMIT),
                .net_out_r(core_if.global_clock_network[g])
            );
        end
    endgenerate

    // regional networks: source from frozen configuration only
    genvar r;
    generate
        for (r = 0; r < RGN_NETS; r++) begin : rgn
            localparam bit PERMIT = (r < RGN_LIMIT);
            wire logic [15:0] cand;
            wire logic src;
            assign cand = {pll_b[5:0], pll_a[5:0], pins};
            assign src = cand[rcfg_r[r][RCFG_SRC +: 4]];
            net_gate u_gate (
                .clk(clk),
                .nrst(nrst),
                .src(src),
                .enable(core_if.rgn_enable[r]),
                .bypass(rcfg_r[r][RCFG_BYPASS]),
                .used(rcfg_r[r][RCFG_USED] & PERMIT),
                .net_out_r(core_if.regional_clock_network[r])
            );
        end
    endgenerate

    // external pin: the sync register cannot be bypassed here
    net_gate u_ext_gate (
        .clk(clk),
        .nrst(nrst),
        .src(pll_a[ecfg_r[ECFG_CNT +: 2]]),
        .enable(core_if.ext_enable),
        .bypass(1'b0),
        .used(ecfg_r[ECFG_USED]),
        .net_out_r(ext_gated)
    );

    // pin io mux set by configuration: core data or gated clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_pin_r <= 1'b0;
        end else begin
            ext_pin_r <= ecfg_r[ECFG_IOMUX] ? ext_gated
                : core_if.ext_io_data;
        end
    end

    // pll references come straight from pins, ahead of any gate,
    // so feedback loops keep running while outputs are off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            center_ref_r <= '0;
            corner_ref_r <= 1'b0;
        end else begin
            center_ref_r <= pins;
            corner_ref_r <= pins[ecfg_r[ECFG_REF +: 2]];
        end
    end

    assign pll_external_output_pin = ext_pin_r;
    assign center_pll_reference = center_ref_r;
    assign corner_pll_reference = corner_ref_r;
endmodule : clock_network_control

/* shared/clock_ctrl_pkg.sv */
// shared constants and types for clock network control
package clock_ctrl_pkg;
    // network counts of the two device variants
    localparam int GLB_NETS = 8;
    localparam int RGN_NETS = 24;
    localparam int GLB_NETS_V2 = 4;
    localparam int RGN_NETS_V2 = 20;
    localparam bit VARIANT_TWO = 1'b0;
    localparam int PIN_COUNT = 4;
    localparam int PLL_CNT = 7;
    // packed source vector: pins, then pll a counters, then pll b counters
    localparam int SRC_W = PIN_COUNT + 2 * PLL_CNT;
    localparam int SRC_PLL_A = PIN_COUNT;
    localparam int SRC_PLL_B = PIN_COUNT + PLL_CNT;
    // counter numbers used by the selectors
    localparam int CNT_ZERO = 0;
    localparam int CNT_ONE = 1;
    localparam int CNT_TWO = 2;
    localparam int CNT_THREE = 3;
    localparam int CNT_FOUR = 4;
    localparam int CNT_FIVE = 5;
    localparam int CNT_SIX = 6;
    // global network configuration word
    localparam int GCFG_W = 12;
    localparam int GCFG_PIN0 = 0;
    localparam int GCFG_PIN1 = 2;
    localparam int GCFG_IN2_PLL = 4;
    localparam int GCFG_IN2_CNT = 5;
    localparam int GCFG_IN3_PLL = 6;
    localparam int GCFG_IN3_CNT = 7;
    localparam int GCFG_LEFT = 8;
    localparam int GCFG_LEFT_C6 = 9;
    localparam int GCFG_USED = 10;
    localparam int GCFG_BYPASS = 11;
    // regional network configuration word
    localparam int RCFG_W = 6;
    localparam int RCFG_SRC = 0;
    localparam int RCFG_USED = 4;
    localparam int RCFG_BYPASS = 5;
    // external output pin configuration word
    localparam int ECFG_W = 6;
    localparam int ECFG_CNT = 0;
    localparam int ECFG_IOMUX = 2;
    localparam int ECFG_USED = 3;
    localparam int ECFG_REF = 4;
    // reset values
    localparam logic GATE_RST = 1'b1;
    localparam logic [GLB_NETS-1:0] GEN_RST = 8'hff;
    localparam logic [RGN_NETS-1:0] REN_RST = 24'hffffff;
    localparam logic [1:0] EXT_RST = 2'h1;
    // register offsets of the core-side controller
    localparam logic [7:0] REG_GSEL = 8'h00;
    localparam logic [7:0] REG_GEN = 8'h04;
    localparam logic [7:0] REG_REN = 8'h08;
    localparam logic [7:0] REG_EXT = 8'h0c;
    localparam logic [7:0] REG_GSTAT = 8'h10;
    localparam logic [7:0] REG_RSTAT = 8'h14;

    typedef enum logic [1:0] {
        SEL_PIN_A = 2'b00,
        SEL_PIN_B = 2'b01,
        SEL_PLL_EVEN = 2'b10,
        SEL_PLL_ODD = 2'b11
    } source_select_t;

    typedef enum logic {
        CFG_LOAD = 1'b0,
        CFG_USER = 1'b1
    } cfg_phase_t;
endpackage : clock_ctrl_pkg

/* shared/clock_ctrl_if.sv */
// interface between core logic and the clock network control
`timescale 1ns/100ps
interface clock_ctrl_if;
    import clock_ctrl_pkg::*;
    logic [GLB_NETS-1:0][1:0] source_select;
    logic [GLB_NETS-1:0] glb_enable;
    logic [RGN_NETS-1:0] rgn_enable;
    logic ext_enable;
    logic ext_io_data;
    logic [GLB_NETS-1:0] global_clock_network;
    logic [RGN_NETS-1:0] regional_clock_network;

    modport device (
        input source_select, glb_enable, rgn_enable, ext_enable, ext_io_data,
        output global_clock_network, regional_clock_network
    );
    modport core (
        output source_select, glb_enable, rgn_enable, ext_enable, ext_io_data,
        input global_clock_network, regional_clock_network
    );
endinterface : clock_ctrl_if

/* design/net_gate.sv */
// glitch-free enable gate for one clock network
`timescale 1ns/100ps
module net_gate
    import clock_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic src,
    input wire logic enable,
    input wire logic bypass,
    input wire logic used,
    output logic net_out_r
);
    logic meta_r;
    logic src_d_r;
    logic gate_r;
    wire logic enable_eff;
    wire logic src_fall;

    // extra register lets core drive enable asynchronously
    assign enable_eff = bypass ? enable : meta_r;
    assign src_fall = src_d_r & ~src;

    // enable taken only on a falling source edge, so no runt pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= GATE_RST;
            src_d_r <= 1'b0;
            gate_r <= GATE_RST;
        end else begin
            meta_r <= enable;
            src_d_r <= src;
            if (src_fall) begin
                gate_r <= enable_eff;
            end
        end
    end

    // gating acts on the network itself; unused means held low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            net_out_r <= 1'b0;
        end else begin
            net_out_r <= used & gate_r & src;
        end
    end
endmodule : net_gate

/* design/core_clock_driver.sv */
// core end: software registers driving selects and enables
`timescale 1ns/100ps
module core_clock_driver
    import clock_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    clock_ctrl_if.core dev_if
);
    logic [2*GLB_NETS-1:0] gsel_r;
    logic [GLB_NETS-1:0] gen_r;
    logic [RGN_NETS-1:0] ren_r;
    logic [1:0] ext_r;
    logic [31:0] rdata_r;
    wire logic wr_gsel;
    wire logic wr_gen;
    wire logic wr_ren;
    wire logic wr_ext;
    wire logic [31:0] rd_mux;

    // write decode
    assign wr_gsel = wr & (addr == REG_GSEL);
    assign wr_gen = wr & (addr == REG_GEN);
    assign wr_ren = wr & (addr == REG_REN);
    assign wr_ext = wr & (addr == REG_EXT);

    // enables reset to on, so used networks run from the start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gsel_r <= '0;
            gen_r <= GEN_RST;
            ren_r <= REN_RST;
            ext_r <= EXT_RST;
        end else begin
            if (wr_gsel) gsel_r <= wdata[2*GLB_NETS-1:0];
            if (wr_gen) gen_r <= wdata[GLB_NETS-1:0];
            if (wr_ren) ren_r <= wdata[RGN_NETS-1:0];
            if (wr_ext) ext_r <= wdata[1:0];
        end
    end

    // read mux; unmapped offsets read zero; network levels are a snapshot
    assign rd_mux =
        (addr == REG_GSEL) ? {16'h0000, gsel_r} :
        (addr == REG_GEN) ? {24'h000000, gen_r} :
        (addr == REG_REN) ? {8'h00, ren_r} :
        (addr == REG_EXT) ? {30'h0, ext_r} :
        (addr == REG_GSTAT) ? {24'h000000, dev_if.global_clock_network} :
        (addr == REG_RSTAT) ? {8'h00, dev_if.regional_clock_network} :
        32'h00000000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rd ? rd_mux : 32'h00000000;
        end
    end

    assign rdata = rdata_r;
    assign dev_if.source_select = gsel_r;
    assign dev_if.glb_enable = gen_r;
    assign dev_if.rgn_enable = ren_r;
    assign dev_if.ext_enable = ext_r[0];
    assign dev_if.ext_io_data = ext_r[1];
endmodule : core_clock_driver

/* tb/clock_ctrl_sva.sv */
// assertions on the core-to-device clock control interface
`timescale 1ns/100ps
module clock_ctrl_sva
    import clock_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [GLB_NETS-1:0][1:0] source_select,
    input wire logic [GLB_NETS-1:0] glb_enable,
    input wire logic [RGN_NETS-1:0] rgn_enable,
    input wire logic ext_enable,
    input wire logic ext_io_data,
    input wire logic [GLB_NETS-1:0] global_clock_network,
    input wire logic [RGN_NETS-1:0] regional_clock_network
);
    localparam int NETS = GLB_NETS + RGN_NETS;
    // sync flops plus one slowest source period: a net may run that long
    localparam logic [6:0] OFF_LIMIT = 7'h50;
    logic [NETS-1:0][6:0] off_cnt_r;
    logic [NETS-1:0] off_vec;
    wire [NETS-1:0] en_all = {rgn_enable, glb_enable};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // cycles each net has spent disabled, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            off_cnt_r <= '0;
        end else begin
            for (int i = 0; i < NETS; i++) begin
                if (en_all[i]) begin
                    off_cnt_r[i] <= 7'h0;
                end else if (off_cnt_r[i] != 7'h64) begin
                    off_cnt_r[i] <= off_cnt_r[i] + 7'h1;
                end
            end
        end
    end

    // nets whose enable has been low long enough to be stopped
    always_comb begin
        for (int i = 0; i < NETS; i++) begin
            off_vec[i] = off_cnt_r[i] >= OFF_LIMIT;
        end
    end

    glb_off_a: assert property (
        (global_clock_network & off_vec[GLB_NETS-1:0]) == '0)
        else $error("disabled global net still toggles");
    rgn_off_a: assert property (
        (regional_clock_network & off_vec[NETS-1:GLB_NETS]) == '0)
        else $error("disabled regional net still toggles");
    start_delay_a: assert property (
        $rose(glb_enable[0]) && $past(off_vec[0]) |->
            (!global_clock_network[0]) [*3])
        else $error("global net restarted without enable sync");
    en_start_a: assert property (
        $rose(nrst) |-> glb_enable == '1 && rgn_enable == '1 &&
            ext_enable && !ext_io_data)
        else $error("enables not on after reset");
    sel_start_a: assert property (
        $rose(nrst) |-> source_select == '0)
        else $error("select not zero after reset");
    min_high_a: assert property (
        $rose(regional_clock_network[0]) |->
            regional_clock_network[0] [*2])
        else $error("truncated high pulse on regional net");
    min_low_a: assert property (
        $fell(regional_clock_network[0]) |->
            (!regional_clock_network[0]) [*2])
        else $error("truncated low phase on regional net");
    unused_off_a: assert property (
        !regional_clock_network[RGN_NETS-1])
        else $error("unused regional net toggles");

    cover property ($rose(glb_enable[0]) && $past(off_vec[0]));
    cover property ($fell(rgn_enable[0]));
    cover property ($rose(regional_clock_network[0]));
    cover property ($fell(ext_enable));
endmodule : clock_ctrl_sva

/* tb/tb.sv */
// self-checking bench joining core driver and device over the interface
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    failures++; $display("unexpected %s: expected %0h seen %0h", \
    nm, exp, got); end end
module tb
    import clock_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] ph = 16'h0;
    logic [SRC_W-1:0] srcv;
    logic [GLB_NETS-1:0][GCFG_W-1:0] cfg_global;
    logic [RGN_NETS-1:0][RCFG_W-1:0] cfg_regional;
    logic [ECFG_W-1:0] cfg_ext = 6'h0d;
    logic ext_pin;
    logic corner_ref;
    logic [PIN_COUNT-1:0] center_ref;
    logic [37:0] all_nets;
    logic [2:0] gb;
    logic [31:0] v;
    int failures = 0;
    int n_checks = 0;
    int p;
    typedef struct { logic [1:0] sel; int e [8]; } row_t;
    row_t rows [4];

    clock_ctrl_if i_clock_ctrl_if ();
    clock_network_control i_clock_network_control (.clk(clk), .nrst(nrst),
        .clock_pin(srcv[3:0]), .pll_a_counter(srcv[10:4]),
        .pll_b_counter(srcv[17:11]), .cfg_global(cfg_global),
        .cfg_regional(cfg_regional), .cfg_ext(cfg_ext),
        .core_if(i_clock_ctrl_if), .pll_external_output_pin(ext_pin),
        .center_pll_reference(center_ref), .corner_pll_reference(corner_ref));
    core_clock_driver i_core_clock_driver (.clk(clk), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .dev_if(i_clock_ctrl_if));
    clock_ctrl_sva i_clock_ctrl_sva (.clk(clk), .nrst(nrst),
        .source_select(i_clock_ctrl_if.source_select),
        .glb_enable(i_clock_ctrl_if.glb_enable),
        .rgn_enable(i_clock_ctrl_if.rgn_enable),
        .ext_enable(i_clock_ctrl_if.ext_enable),
        .ext_io_data(i_clock_ctrl_if.ext_io_data),
        .global_clock_network(i_clock_ctrl_if.global_clock_network),
        .regional_clock_network(i_clock_ctrl_if.regional_clock_network));

    initial begin
        forever #2 clk = ~clk;
    end

    // sources: five distinct rates, repeating every five source bits, so some select choices share a period
    always @(posedge clk) ph <= ph + 16'h1;
    always_comb begin
        for (int k = 0; k < SRC_W; k++) srcv[k] = ph[k % 5 + 1];
    end
    assign all_nets = {center_ref, corner_ref, ext_pin,
        i_clock_ctrl_if.regional_clock_network,
        i_clock_ctrl_if.global_clock_network};

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    // cycles between two falls; 0 if the net does not give them within 300 cycles
    task automatic period_of(input int k, output int q);
        int c;
        c = 0;
        q = 0;
        while (all_nets[k] !== 1'b1 && c < 300) begin @(negedge clk); c++; end
        while (all_nets[k] !== 1'b0 && c < 300) begin @(negedge clk); c++; end
        while (all_nets[k] !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
            q++;
        end
        while (all_nets[k] !== 1'b0 && c < 300) begin
            @(negedge clk);
            c++;
            q++;
        end
        if (c >= 300) q = 0;
    endtask : period_of

    task automatic rises(input int k, input int n, output int r);
        logic last;
        r = 0;
        last = all_nets[k];
        repeat (n) begin
            @(negedge clk);
            if (all_nets[k] === 1'b1 && last !== 1'b1) r++;
            last = all_nets[k];
        end
    endtask : rises

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        for (int g = 0; g < GLB_NETS; g++) begin
            gb = 3'(g);
            cfg_global[g] = {gb[0], 1'b1, 2'b00, gb[2], gb[1], gb[1], gb[0],
                2'(g + 1), 2'(g)};
        end
        for (int r = 0; r < RGN_NETS; r++) begin
            cfg_regional[r] = {1'b0, 1'(r != RGN_NETS - 1), 4'(r)};
        end
        rows = '{'{2'h0, '{0, 1, 2, 3, 0, 1, 2, 3}},
            '{2'h1, '{1, 2, 3, 0, 1, 2, 3, 0}},
            '{2'h2, '{4, 1, 1, 3, 4, 1, 1, 3}},
            '{2'h3, '{0, 0, 2, 2, 2, 2, 4, 4}}};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // one select for all globals, then the period of every global net
        foreach (rows[i]) begin
            wr_reg(REG_GSEL, {16'h0, {8{rows[i].sel}}});
            @(negedge clk);
            `CHK("select", {8{rows[i].sel}}, i_clock_ctrl_if.source_select)
            repeat (80) @(negedge clk);
            for (int g = 0; g < GLB_NETS; g++) begin
                period_of(g, p);
                `CHK("global period", 4 << rows[i].e[g], p)
            end
        end
        wr_reg(REG_GEN, 32'hfe);
        repeat (100) @(negedge clk);
        rd_reg(REG_GSTAT, v);
        `CHK("global status", 32'h0, v & 32'hffffff01)
        rises(0, 64, p);
        `CHK("gated global", 0, p)
        rises(1, 64, p);
        `CHK("free global", 16, p)
        wr_reg(REG_GEN, 32'hff);
        repeat (20) @(negedge clk);
        rises(0, 64, p);
        `CHK("regated global", 16, p)
        // regional net 0 runs from a pin, no pll in the path
        wr_reg(REG_REN, 32'hfffffe);
        repeat (100) @(negedge clk);
        rd_reg(REG_RSTAT, v);
        `CHK("regional status", 32'h0, v & 32'hff800001)
        rises(8, 64, p);
        `CHK("gated regional", 0, p)
        wr_reg(REG_REN, 32'hffffff);
        rises(31, 64, p);
        `CHK("unused regional", 0, p)
        period_of(32, p);
        `CHK("ext pin period", 4, p)
        wr_reg(REG_EXT, 32'h0);
        repeat (100) @(negedge clk);
        rises(32, 64, p);
        `CHK("ext pin gated", 0, p)
        wr_reg(REG_EXT, 32'h1);
        period_of(33, p);
        `CHK("corner ref", 4, p)
        for (int i = 0; i < PIN_COUNT; i++) begin
            period_of(34 + i, p);
            `CHK("center ref", 4 << i, p)
        end
        wr_reg(8'h20, 32'h5);
        rd_reg(8'h20, v);
        `CHK("unmapped read", 32'h0, v)
        // second reset: io mux now carries the plain data bit
        @(posedge clk);
        nrst <= 1'b0;
        cfg_ext <= 6'h09;
        // global 7 turns into a left-side net: counters only
        cfg_global[7][GCFG_LEFT +: 2] <= 2'b11;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(REG_GEN, v);
        `CHK("global enables", 32'hff, v)
        rd_reg(REG_REN, v);
        `CHK("regional enables", 32'hffffff, v)
        rd_reg(REG_EXT, v);
        `CHK("ext control", 32'h1, v)
        @(posedge clk);
        cfg_regional[1] <= {2'b01, 4'h3};
        repeat (100) @(negedge clk);
        period_of(9, p);
        `CHK("static regional source", 8, p)
        period_of(7, p);
        `CHK("left input zero", 4, p)
        wr_reg(REG_GSEL, 32'h4000);
        repeat (20) @(negedge clk);
        period_of(7, p);
        `CHK("left input one", 64, p)
        wr_reg(REG_EXT, 32'h3);
        repeat (20) @(negedge clk);
        `CHK("io data high", 1'b1, ext_pin)
        wr_reg(REG_EXT, 32'h1);
        repeat (20) @(negedge clk);
        `CHK("io data low", 1'b0, ext_pin)
        test_done();
    end
endmodule : tb
